//--- core/fbsoh_params.svh
// fbsoh_params.svh: constants of the fieldbus slave output-hold block
// assumes: included by bare name by every module and interface file of the block
`ifndef FBSOH_PARAMS_SVH
`define FBSOH_PARAMS_SVH

`define FBSOH_ADDR_W      7
`define FBSOH_ADDR_MIN    7'h01
`define FBSOH_ADDR_MAX    7'h7d
`define FBSOH_ADDR_SVC    7'h00
`define FBSOH_CMD_W       3
`define FBSOH_CMD_DATA    3'h0
`define FBSOH_CMD_SYNC    3'h1
`define FBSOH_CMD_UNSYNC  3'h2
`define FBSOH_CMD_FREEZE  3'h3
`define FBSOH_CMD_UNFRZ   3'h4
`define FBSOH_CMD_PRM     3'h5
`define FBSOH_CMD_START   3'h6
`define FBSOH_WD_W        24
`define FBSOH_WD_DEF      24'h0f4240
`define FBSOH_ONE_WD      24'h000001

`endif

//--- core/fbsoh_pkg.sv
// fbsoh_pkg: types of the fieldbus slave output-hold block
// assumes: compiled before every module of the block
package fbsoh_pkg;
	typedef enum logic [1:0] {
		FBSOH_WAIT_PRM,
		FBSOH_WAIT_START,
		FBSOH_EXCHANGE,
		FBSOH_SAFE
	} fbsoh_state_t;
endpackage

//--- core/fbsoh_frame_if.sv
// fbsoh_frame_if: decoded frame events between the filter and the core
// assumes: one clock; all members valid in the cycle of frameOk
`timescale 1ns/1ps
`include "fbsoh_params.svh"
interface fbsoh_frame_if;
	logic                       frameOk;
	logic                       ownHit;
	logic                       groupHit;
	logic [`FBSOH_CMD_W-1:0]    cmd;
	modport filt (output frameOk, output ownHit, output groupHit, output cmd);
	modport core (input frameOk, input ownHit, input groupHit, input cmd);
endinterface

//--- core/fbsoh_addr_filter.sv
// fbsoh_addr_filter: address check and command qualification
// assumes: frame fields are from logic on the same clock
`timescale 1ns/1ps
`include "fbsoh_params.svh"
module fbsoh_addr_filter
	import fbsoh_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    srst,
	input  wire logic                    rxValid,
	input  wire logic                    rxGroup,
	input  wire logic [`FBSOH_ADDR_W-1:0] rxDest,
	input  wire logic [`FBSOH_CMD_W-1:0]  rxCmd,
	input  wire logic [`FBSOH_ADDR_W-1:0] stationAddr,
	fbsoh_frame_if.filt                  fr
);
	// ********************************
	// address check
	// ********************************
	logic addrLegal;
	logic okD, okQ, ownD, ownQ, grpD, grpQ;
	logic [`FBSOH_CMD_W-1:0] cmdD, cmdQ;

	always_comb begin
		// own address outside 1..125 never matches; 0 is a service address
		addrLegal = (stationAddr >= `FBSOH_ADDR_MIN) &&
			(stationAddr <= `FBSOH_ADDR_MAX);
		ownD = rxValid && !rxGroup && addrLegal &&
			(rxDest == stationAddr);
		// group commands bypass the address match
		grpD = rxValid && rxGroup && addrLegal &&
			((rxCmd == `FBSOH_CMD_SYNC) ||
			(rxCmd == `FBSOH_CMD_UNSYNC) ||
			(rxCmd == `FBSOH_CMD_FREEZE) ||
			(rxCmd == `FBSOH_CMD_UNFRZ));
		okD = ownD || grpD;
		cmdD = rxCmd;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			okQ  <= 1'b0;
			ownQ <= 1'b0;
			grpQ <= 1'b0;
			cmdQ <= `FBSOH_CMD_DATA;
		end else begin
			okQ  <= okD;
			ownQ <= ownD;
			grpQ <= grpD;
			cmdQ <= cmdD;
		end
	end

	assign fr.frameOk  = okQ;
	assign fr.ownHit   = ownQ;
	assign fr.groupHit = grpQ;
	assign fr.cmd      = cmdQ;
endmodule // fbsoh_addr_filter

//--- core/fbsoh_output_hold.sv
// fbsoh_output_hold: output hold, input freeze and response watchdog
// assumes: frames arrive decoded on clk; process inputs come from pins
// Functional notes
// - SYNC holds outputs; later output data is stored, not applied
// - each further SYNC applies latest stored data, then holds again
// - outputs follow every frame again only after UNSYNC or the safe state
// - no own frame within watchdog time: safe state, outputs zero
// - station addresses 1 to 125; address 0 for service tools
// - no data exchange until master prompts the slave
// - FREEZE latches inputs; each FREEZE relatches; UNFREEZE goes live
`timescale 1ns/1ps
`include "fbsoh_params.svh"
module fbsoh_output_hold
	import fbsoh_pkg::*;
#(
	parameter int                    DATA_W = 8,
	parameter logic [`FBSOH_WD_W-1:0] WD_CYCLES = `FBSOH_WD_DEF
) (
	input  wire logic                     clk,
	input  wire logic                     srst,
	input  wire logic                     rxValid,
	input  wire logic                     rxGroup,
	input  wire logic [`FBSOH_ADDR_W-1:0] rxDest,
	input  wire logic [`FBSOH_CMD_W-1:0]  rxCmd,
	input  wire logic [DATA_W-1:0]        rxOutData,
	input  wire logic [`FBSOH_ADDR_W-1:0] stationAddr,
	input  wire logic [DATA_W-1:0]        procIn,
	output logic      [DATA_W-1:0]        procOut,
	output logic      [DATA_W-1:0]        txInData,
	output logic                          exchActive,
	output logic                          safeState,
	output logic                          syncActive,
	output logic                          freezeActive
);
	// ********************************
	// frame path
	// ********************************
	fbsoh_frame_if fr ();
	logic [DATA_W-1:0] dataQ;

	fbsoh_addr_filter u_filt (
		.clk         (clk),
		.srst        (srst),
		.rxValid     (rxValid),
		.rxGroup     (rxGroup),
		.rxDest      (rxDest),
		.rxCmd       (rxCmd),
		.stationAddr (stationAddr),
		.fr          (fr)
	);

	// data delayed to line up with the registered frame events
	always_ff @(posedge clk) begin
		if (srst) begin
			dataQ <= '0;
		end else begin
			dataQ <= rxOutData;
		end
	end

	// ********************************
	// input synchroniser
	// ********************************
	// three stages; a bit changes once stages two and three agree
	logic [DATA_W-1:0] s1Q, s2Q, s3Q, inStableQ, inStableD;
	always_comb begin
		for (int i = 0; i < DATA_W; i++) begin
			inStableD[i] = (s2Q[i] == s3Q[i]) ? s3Q[i] : inStableQ[i];
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			s1Q       <= '0;
			s2Q       <= '0;
			s3Q       <= '0;
			inStableQ <= '0;
		end else begin
			s1Q       <= procIn;
			s2Q       <= s1Q;
			s3Q       <= s2Q;
			inStableQ <= inStableD;
		end
	end

	// ********************************
	// station state and watchdog
	// ********************************
	fbsoh_state_t stQ, stD;
	logic [`FBSOH_WD_W-1:0] wdQ, wdD;
	logic ownOk, cmdPrm, cmdStart;

	always_comb begin
		ownOk    = fr.frameOk && fr.ownHit;
		cmdPrm   = ownOk && (fr.cmd == `FBSOH_CMD_PRM);
		cmdStart = ownOk && (fr.cmd == `FBSOH_CMD_START);
		stD = stQ;
		wdD = wdQ;
		case (stQ)
			// parameters come from the parameter master first
			FBSOH_WAIT_PRM: begin
				if (cmdPrm) begin
					stD = FBSOH_WAIT_START;
				end
			end
			FBSOH_WAIT_START: begin
				if (cmdStart) begin
					stD = FBSOH_EXCHANGE;
					wdD = WD_CYCLES;
				end
			end
			FBSOH_EXCHANGE: begin
				if (ownOk) begin
					wdD = WD_CYCLES;
				end else if (wdQ <= `FBSOH_ONE_WD) begin
					stD = FBSOH_SAFE;
					wdD = '0;
				end else begin
					wdD = wdQ - `FBSOH_ONE_WD;
				end
			end
			// leaving safe state needs a fresh parameter/start sequence
			FBSOH_SAFE: begin
				if (cmdPrm) begin
					stD = FBSOH_WAIT_START;
				end
			end
			default: begin
				stD = FBSOH_WAIT_PRM;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			stQ <= FBSOH_WAIT_PRM;
			wdQ <= '0;
		end else begin
			stQ <= stD;
			wdQ <= wdD;
		end
	end

	// ********************************
	// output hold and input freeze
	// ********************************
	logic [DATA_W-1:0] outD, outQ, storeD, storeQ, frzD, frzQ, txD, txQ;
	logic syncD, syncQ, frzOnD, frzOnQ, exch, isSync, isUnsync;
	logic isFrz, isUnfrz, isData;

	always_comb begin
		exch     = (stQ == FBSOH_EXCHANGE);
		isData   = ownOk && (fr.cmd == `FBSOH_CMD_DATA) && exch;
		// group commands only act on a slave in data exchange
		isSync   = fr.frameOk && fr.groupHit && exch &&
			(fr.cmd == `FBSOH_CMD_SYNC);
		isUnsync = fr.frameOk && fr.groupHit && exch &&
			(fr.cmd == `FBSOH_CMD_UNSYNC);
		isFrz    = fr.frameOk && fr.groupHit && exch &&
			(fr.cmd == `FBSOH_CMD_FREEZE);
		isUnfrz  = fr.frameOk && fr.groupHit && exch &&
			(fr.cmd == `FBSOH_CMD_UNFRZ);
		outD   = outQ;
		storeD = storeQ;
		syncD  = syncQ;
		frzD   = frzQ;
		frzOnD = frzOnQ;
		if (isData) begin
			storeD = dataQ;
			if (!syncQ) begin
				outD = dataQ;
			end
		end
		if (isSync) begin
			// first SYNC freezes, later ones apply the stored data once
			if (syncQ) begin
				outD = storeQ;
			end
			syncD = 1'b1;
		end else if (isUnsync) begin
			syncD = 1'b0;
		end
		if (isFrz) begin
			frzD   = inStableQ;
			frzOnD = 1'b1;
		end else if (isUnfrz) begin
			frzOnD = 1'b0;
		end
		txD = frzOnD ? frzD : inStableQ;
		// follows exchActive, so reported data drops in the same cycle
		if (stD != FBSOH_EXCHANGE) begin
			txD = '0;
		end
		// safe state overrides everything; mode flags also drop
		if (stD == FBSOH_SAFE || stQ == FBSOH_SAFE) begin
			outD   = '0;
			syncD  = 1'b0;
			frzOnD = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			outQ   <= '0;
			storeQ <= '0;
			frzQ   <= '0;
			txQ    <= '0;
			syncQ  <= 1'b0;
			frzOnQ <= 1'b0;
		end else begin
			outQ   <= outD;
			storeQ <= storeD;
			frzQ   <= frzD;
			txQ    <= txD;
			syncQ  <= syncD;
			frzOnQ <= frzOnD;
		end
	end

	// registered status flags
	logic exchQ, safeQ;
	always_ff @(posedge clk) begin
		if (srst) begin
			exchQ <= 1'b0;
			safeQ <= 1'b0;
		end else begin
			exchQ <= (stD == FBSOH_EXCHANGE);
			safeQ <= (stD == FBSOH_SAFE);
		end
	end

	assign procOut      = outQ;
	assign txInData     = txQ;
	assign exchActive   = exchQ;
	assign safeState    = safeQ;
	assign syncActive   = syncQ;
	assign freezeActive = frzOnQ;
endmodule // fbsoh_output_hold

//--- dv/fbsoh_output_hold_properties.sv
// fbsoh_output_hold_properties: assertions on the output-hold block
// assumes: bound to fbsoh_output_hold, sees its ports only
`timescale 1ns/1ps
`include "fbsoh_params.svh"
module fbsoh_output_hold_checker
	import fbsoh_pkg::*;
#(
	parameter int                     DATA_W    = 8,
	parameter logic [`FBSOH_WD_W-1:0] WD_CYCLES = `FBSOH_WD_DEF
) (
	input wire logic                     clk,
	input wire logic                     srst,
	input wire logic                     rxValid,
	input wire logic                     rxGroup,
	input wire logic [`FBSOH_ADDR_W-1:0] rxDest,
	input wire logic [`FBSOH_CMD_W-1:0]  rxCmd,
	input wire logic [DATA_W-1:0]        rxOutData,
	input wire logic [`FBSOH_ADDR_W-1:0] stationAddr,
	input wire logic [DATA_W-1:0]        procIn,
	input wire logic [DATA_W-1:0]        procOut,
	input wire logic [DATA_W-1:0]        txInData,
	input wire logic                     exchActive,
	input wire logic                     safeState,
	input wire logic                     syncActive,
	input wire logic                     freezeActive
);
	// ****
	// properties
	// ****
	wire own = rxValid && !rxGroup && rxDest == stationAddr;
	wire frz = rxValid && rxGroup && rxCmd == `FBSOH_CMD_FREEZE;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_safe_zero: assert property (
		safeState |-> procOut == '0 && !exchActive)
		else $error("outputs live in safe state");
	a_data_apply: assert property (
		own && rxCmd == `FBSOH_CMD_DATA && exchActive && !syncActive
		&& !$past(rxValid) ##1 exchActive && !syncActive
		|=> procOut == $past(rxOutData, 2)) else $error("data not applied");
	a_sync_hold: assert property (
		syncActive && $past(syncActive) && $changed(procOut)
		|-> $past(rxValid && rxGroup && rxCmd == `FBSOH_CMD_SYNC, 2))
		else $error("held outputs changed");
	a_frz_hold: assert property (
		freezeActive && $past(freezeActive, 4) && !$past(frz)
		&& !$past(frz, 2) && !$past(frz, 3) && !$past(frz, 4)
		|-> $stable(txInData)) else $error("frozen inputs changed");
	a_start_prompt: assert property (
		$rose(exchActive) |-> $past(own && rxCmd == `FBSOH_CMD_START, 2))
		else $error("exchange without prompt");
	a_addr_legal: assert property (
		$rose(exchActive) |-> $past(stationAddr, 2)
		inside {[`FBSOH_ADDR_MIN:`FBSOH_ADDR_MAX]}) else $error("bad address");
	a_wd_reload: assert property (
		own && exchActive && !safeState ##1 exchActive
		|-> ##1 !safeState [*8])
		else $error("watchdog not restarted");
	a_foreign_ign: assert property (
		rxValid && !rxGroup && rxDest != stationAddr ##1 !rxValid
		|=> $stable(procOut) && $stable(syncActive))
		else $error("foreign frame acted on");
	c_sync: cover property ($rose(syncActive));
	c_safe: cover property ($rose(safeState));
	c_frz: cover property ($rose(freezeActive));
endmodule // fbsoh_output_hold_checker

bind fbsoh_output_hold fbsoh_output_hold_checker #(.DATA_W(DATA_W),
	.WD_CYCLES(WD_CYCLES)) fbsoh_output_hold_checker_i (.clk, .srst,
	.rxValid, .rxGroup, .rxDest, .rxCmd, .rxOutData, .stationAddr, .procIn,
	.procOut, .txInData, .exchActive, .safeState, .syncActive, .freezeActive);

//--- dv/fbsoh_master_model.sv
// fbsoh_master_model: bus master issuing decoded frames
// assumes: one clock; frames launched at the falling edge
`timescale 1ns/1ps
`include "fbsoh_params.svh"
module fbsoh_master_model (
	input  wire logic                clk,
	output logic                     rxValid,
	output logic                     rxGroup,
	output logic [`FBSOH_ADDR_W-1:0] rxDest,
	output logic [`FBSOH_CMD_W-1:0]  rxCmd,
	output logic [7:0]               rxOutData
);
	// ****
	// frame driver
	// ****
	initial begin
		rxValid = 1'b0;
		rxGroup = 1'b0;
		rxDest = 7'h00;
		rxCmd = 3'h7;
		rxOutData = 8'h00;
	end
	// released fields show the inverse so a stale value never matches
	task send(input logic g, input logic [6:0] d, input logic [2:0] c,
		input logic [7:0] v);
		@(negedge clk);
		rxValid = 1'b1;
		rxGroup = g;
		rxDest = d;
		rxCmd = c;
		rxOutData = v;
		@(negedge clk);
		rxValid = 1'b0;
		rxGroup = ~g;
		rxDest = ~d;
		rxCmd = ~c;
		rxOutData = ~v;
		repeat (2) @(negedge clk);
	endtask
endmodule // fbsoh_master_model

//--- dv/fbsoh_output_hold_tb.sv
// fbsoh_output_hold_tb: self-checking bench of the output-hold block
// assumes: master model drives frames; watchdog shortened to 40 cycles
`timescale 1ns/1ps
`include "fbsoh_params.svh"
module fbsoh_output_hold_tb;
	// ****
	// harness
	// ****
	logic       clk;
	logic       srst;
	logic [6:0] stationAddr;
	logic [7:0] procIn;
	wire        rxValid, rxGroup, exchActive, safeState, syncActive, frzOn;
	wire [6:0]  rxDest;
	wire [2:0]  rxCmd;
	wire [7:0]  rxOutData, procOut, txInData;
	int         mismatches = 0;
	int         checked = 0;
	fbsoh_master_model fbsoh_master_model_i (.clk, .rxValid, .rxGroup,
		.rxDest, .rxCmd, .rxOutData);
	fbsoh_output_hold #(.DATA_W(8), .WD_CYCLES(24'h000028))
		fbsoh_output_hold_i (.clk, .srst, .rxValid, .rxGroup, .rxDest,
		.rxCmd, .rxOutData, .stationAddr, .procIn, .procOut, .txInData,
		.exchActive, .safeState, .syncActive, .freezeActive(frzOn));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task own(input logic [2:0] c, input logic [7:0] v);
		fbsoh_master_model_i.send(1'b0, stationAddr, c, v);
	endtask
	task grp(input logic [2:0] c);
		fbsoh_master_model_i.send(1'b1, 7'h00, c, 8'h00);
	endtask
	task up(input logic [6:0] a);
		stationAddr = a;
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		own(`FBSOH_CMD_DATA, 8'h3c);
		chk(procOut, 8'h00);
		own(`FBSOH_CMD_PRM, 8'h00);
		own(`FBSOH_CMD_START, 8'h00);
	endtask
	// ****
	// scenarios
	// ****
	task t_data;
		up(7'h05);
		chk(8'(exchActive), 8'h01);
		own(`FBSOH_CMD_DATA, 8'h3c);
		chk(procOut, 8'h3c);
		fbsoh_master_model_i.send(1'b0, 7'h06, `FBSOH_CMD_DATA, 8'hc3);
		chk(procOut, 8'h3c);
		grp(`FBSOH_CMD_DATA);
		chk(procOut, 8'h3c);
	endtask
	task t_sync;
		grp(`FBSOH_CMD_SYNC);
		chk(8'(syncActive), 8'h01);
		own(`FBSOH_CMD_DATA, 8'ha5);
		chk(procOut, 8'h3c);
		own(`FBSOH_CMD_DATA, 8'h5a);
		grp(`FBSOH_CMD_SYNC);
		chk(procOut, 8'h5a);
		own(`FBSOH_CMD_DATA, 8'h66);
		chk(procOut, 8'h5a);
		grp(`FBSOH_CMD_UNSYNC);
		chk(8'(syncActive), 8'h00);
		own(`FBSOH_CMD_DATA, 8'h11);
		chk(procOut, 8'h11);
	endtask
	task t_freeze;
		procIn = 8'h81;
		own(`FBSOH_CMD_DATA, 8'h11);
		grp(`FBSOH_CMD_FREEZE);
		chk(8'(frzOn), 8'h01);
		procIn = 8'h7e;
		own(`FBSOH_CMD_DATA, 8'h11);
		own(`FBSOH_CMD_DATA, 8'h11);
		chk(txInData, 8'h81);
		grp(`FBSOH_CMD_FREEZE);
		own(`FBSOH_CMD_DATA, 8'h11);
		chk(txInData, 8'h7e);
		grp(`FBSOH_CMD_UNFRZ);
		chk(8'(frzOn), 8'h00);
		procIn = 8'h42;
		own(`FBSOH_CMD_DATA, 8'h11);
		own(`FBSOH_CMD_DATA, 8'h11);
		chk(txInData, 8'h42);
	endtask
	task t_safe;
		// group frames do not feed the watchdog; modes must drop in safe
		grp(`FBSOH_CMD_SYNC);
		grp(`FBSOH_CMD_FREEZE);
		chk(8'(syncActive), 8'h01);
		for (int i = 0; i < 100 && safeState !== 1'b1; i++) @(negedge clk);
		if (safeState !== 1'b1) begin
			mismatches++;
			test_done();
		end else begin
			chk(procOut, 8'h00);
			chk(8'(exchActive), 8'h00);
			chk(txInData, 8'h00);
			chk(8'(syncActive), 8'h00);
			chk(8'(frzOn), 8'h00);
			own(`FBSOH_CMD_DATA, 8'h3c);
			chk(procOut, 8'h00);
			own(`FBSOH_CMD_PRM, 8'h00);
			own(`FBSOH_CMD_START, 8'h00);
			chk(8'(exchActive), 8'h01);
			chk(procOut, 8'h00);
		end
	endtask
	initial begin
		srst = 1'b1;
		stationAddr = 7'h05;
		procIn = 8'h00;
		t_data();
		t_sync();
		t_freeze();
		t_safe();
		up(7'h00);
		chk(8'(exchActive), 8'h00);
		up(7'h7e);
		chk(8'(exchActive), 8'h00);
		up(7'h7d);
		chk(8'(exchActive), 8'h01);
		test_done();
	end
endmodule // fbsoh_output_hold_tb
